/* File: logic/exec_unit.sv */
// Execution unit for relative flag branches, I/O bit set/clear, shifts,
// rotates through carry, transfer-flag bit moves and flag set/clear.
// Assumes a master that issues one-cycle read/write strobes on clk and
// polls busy before issuing the next command.
//
// Contract
// - With overflow clear the branch loads pc+offset+1 in 2 cycles, else 1.
// - With interrupt enable set the branch jumps, 1 or 2 cycles, no flags.
// - With interrupt enable clear the branch jumps, 1 or 2 cycles, no flags.
// - I/O bit set forces one I/O bit to 1, keeps the rest, two cycles.
// - I/O bit clear forces one I/O bit to 0, keeps the rest, two cycles.
// - Logical left shift inserts 0 at bit 0 and updates Z, C, N, V.
// - Logical right shift inserts 0 at bit 7 and updates Z, C, N, V.
// - Rotate left puts old carry in bit 0 and old bit 7 in carry.
// - Rotate right puts old carry in bit 7 and old bit 0 in carry.
// - Arithmetic right shift keeps bit 7 and updates Z, C, N, V.
// - Bit store copies one register bit into the transfer flag only.
// - Bit load copies the transfer flag into one register bit, no flags.
// - Single-cycle ops set or clear only the half-carry flag.
// - Single-cycle ops set or clear only the overflow flag.
// - Single-cycle ops set or clear only the signed-test flag.
// - Generic branch-if-set jumps when the selected status bit is 1, branch-if-clear when it is 0.
//
// The register offsets and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ps

module exec_unit #(
  parameter int NUM_REGS = 32
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // Register port
  input  wire logic [exec_pkg::ADDR_W-1:0] addr,
  input  wire logic [exec_pkg::DATA_W-1:0] wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output logic      [exec_pkg::DATA_W-1:0] rdata,
  // Core state
  output logic                             busy,
  output logic                             done,
  output logic      [7:0]                  status_flags_word,
  output logic      [exec_pkg::PC_W-1:0]   pc
);

  // ****************************************
  // Helpers
  // ****************************************
  // True for a word-aligned address inside one 32-word register window
  function automatic logic in_window(input logic [9:0] a,
                                     input logic [9:0] base);
    in_window = (a[9:exec_pkg::WIN_LSB] == base[9:exec_pkg::WIN_LSB]) &&
                (a[exec_pkg::IDX_LSB-1:0] == 2'h0);
  endfunction

  // Returns {carry_out, result} of a shift or rotate
  function automatic logic [8:0] shift_op(input exec_pkg::op_t op,
                                          input logic [7:0] v,
                                          input logic c);
    case (op)
      exec_pkg::OP_SHIFT_LEFT_LOGICAL:  shift_op = {v[7], v[6:0], 1'b0};
      exec_pkg::OP_SHIFT_RIGHT_LOGICAL: shift_op = {v[0], 1'b0, v[7:1]};
      exec_pkg::OP_ROTATE_LEFT_CARRY:   shift_op = {v[7], v[6:0], c};
      exec_pkg::OP_ROTATE_RIGHT_CARRY:  shift_op = {v[0], c, v[7:1]};
      exec_pkg::OP_SHIFT_RIGHT_ARITH:   shift_op = {v[0], v[7], v[7:1]};
      default:                          shift_op = {c, v};
    endcase
  endfunction

  // ****************************************
  // Decode
  // ****************************************
  typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_HOLD} state_t;

  state_t              state;
  state_t              next_state;
  // Accepted command, kept after it ends for readback
  exec_pkg::cmd_t      cur;
  logic [7:0]          gpr [NUM_REGS];
  logic [7:0]          io_reg [NUM_REGS];

  wire exec_pkg::cmd_t cmd_in   = exec_pkg::cmd_t'(
                                    wdata[exec_pkg::CMD_W-1:0]);
  wire                 sel_cmd  = addr == exec_pkg::ADDR_CMD;
  wire                 sel_flag = addr == exec_pkg::ADDR_FLAGS;
  wire                 sel_pc   = addr == exec_pkg::ADDR_PC;
  wire                 sel_gpr  = in_window(addr, exec_pkg::GPR_BASE);
  wire                 sel_io   = in_window(addr, exec_pkg::IO_BASE);
  wire [4:0]           widx     = addr[exec_pkg::WIN_LSB-1:
                                       exec_pkg::IDX_LSB];
  // Commands written while busy are dropped, not queued
  wire                 start    = wr_en && sel_cmd && (state == ST_IDLE);
  wire                 in_exec  = state == ST_EXEC;
  wire                 in_hold  = state == ST_HOLD;

  wire [7:0]           gval     = gpr[cur.index];
  wire [7:0]           ival     = io_reg[cur.index];
  wire [8:0]           sh       = shift_op(cur.op, gval,
                                           status_flags_word[exec_pkg::F_C]);
  wire                 sh_n     = sh[7];
  wire                 sh_v     = sh_n ^ sh[8];
  wire                 is_shift = cur.op inside {
                                    exec_pkg::OP_SHIFT_LEFT_LOGICAL,
                                    exec_pkg::OP_SHIFT_RIGHT_LOGICAL,
                                    exec_pkg::OP_ROTATE_LEFT_CARRY,
                                    exec_pkg::OP_ROTATE_RIGHT_CARRY,
                                    exec_pkg::OP_SHIFT_RIGHT_ARITH};
  wire                 is_io    = cur.op inside {exec_pkg::OP_IO_BIT_SET,
                                                 exec_pkg::OP_IO_BIT_CLEAR};

  // Dedicated flag ops are laid out in set/clear pairs by flag index
  // Codes past the last pair fold onto flag bits as well; avoid them
  wire [5:0]           fop_rel  = 6'(cur.op - exec_pkg::OP_CARRY_SET);
  wire                 is_fop   = cur.op >= exec_pkg::OP_CARRY_SET;
  wire                 is_gfop  = cur.op inside {exec_pkg::OP_FLAG_SET,
                                                 exec_pkg::OP_FLAG_CLEAR};
  wire [2:0]           fop_idx  = is_gfop ? cur.flag_sel : fop_rel[3:1];
  wire                 fop_val  = is_gfop ?
                                  (cur.op == exec_pkg::OP_FLAG_SET) :
                                  !fop_rel[0];

  // Branch condition, low for every other op
  logic taken;
  always_comb begin
    case (cur.op)
      exec_pkg::OP_BRANCH_NO_OVERFLOW:
        taken = !status_flags_word[exec_pkg::F_V];
      exec_pkg::OP_BRANCH_IRQ_ON:
        taken = status_flags_word[exec_pkg::F_I];
      exec_pkg::OP_BRANCH_IRQ_OFF:
        taken = !status_flags_word[exec_pkg::F_I];
      exec_pkg::OP_BRANCH_FLAG_SET:
        taken = status_flags_word[cur.flag_sel];
      exec_pkg::OP_BRANCH_FLAG_CLEAR:
        taken = !status_flags_word[cur.flag_sel];
      default:
        taken = 1'b0;
    endcase
  end

  wire [15:0] target = pc + {{9{cur.offset[6]}}, cur.offset} + 16'h0001;

  // ****************************************
  // Sequencing
  // ****************************************
  // Taken branches and I/O bit ops spend a second cycle in HOLD
  // Branches not taken and all other ops finish in EXEC alone
  always_comb begin
    case (state)
      ST_IDLE: next_state = start ? ST_EXEC : ST_IDLE;
      ST_EXEC: next_state = (taken || is_io) ? ST_HOLD : ST_IDLE;
      ST_HOLD: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= ST_IDLE;
      busy  <= 1'b0;
      done  <= 1'b0;
      cur   <= '0;
    end else begin
      state <= next_state;
      // Decoded from next_state so both outputs come straight from flops
      busy  <= next_state != ST_IDLE;
      done  <= (state != ST_IDLE) && (next_state == ST_IDLE);
      if (start) begin
        cur <= cmd_in;
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  // Execution wins over a software write in the same cycle
  logic [7:0] next_flags;
  always_comb begin
    next_flags = status_flags_word;
    if (wr_en && sel_flag) begin
      next_flags = wdata[7:0];
    end
    // Shifts leave S, H, T and I alone
    if (in_exec && is_shift) begin
      next_flags[exec_pkg::F_Z] = sh[7:0] == 8'h00;
      next_flags[exec_pkg::F_C] = sh[8];
      next_flags[exec_pkg::F_N] = sh_n;
      next_flags[exec_pkg::F_V] = sh_v;
    end
    if (in_exec && cur.op == exec_pkg::OP_BIT_TO_TRANSFER_FLAG) begin
      next_flags[exec_pkg::F_T] = gval[cur.bit_sel];
    end
    if (in_exec && (is_fop || is_gfop)) begin
      next_flags[fop_idx] = fop_val;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_flags_word <= exec_pkg::FLAGS_RST;
    end else begin
      status_flags_word <= next_flags;
    end
  end

  // ****************************************
  // Program counter
  // ****************************************
  // Only a taken branch or a write to ADDR_PC moves pc; stepping past other ops is done outside
  wire [15:0] next_pc = (in_exec && taken) ? target :
                        (wr_en && sel_pc)  ? wdata[15:0] : pc;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pc <= exec_pkg::PC_RST;
    end else begin
      pc <= next_pc;
    end
  end

  // ****************************************
  // General registers
  // ****************************************
  // Bit load: the register with one bit replaced by T
  logic [7:0] bld_val;
  always_comb begin
    bld_val = gval;
    bld_val[cur.bit_sel] = status_flags_word[exec_pkg::F_T];
  end

  wire g_exec = in_exec && (is_shift ||
                cur.op == exec_pkg::OP_NIBBLE_SWAP ||
                cur.op == exec_pkg::OP_TRANSFER_FLAG_TO_BIT);
  wire [7:0] g_res = is_shift ? sh[7:0] :
                     (cur.op == exec_pkg::OP_NIBBLE_SWAP) ?
                     {gval[3:0], gval[7:4]} : bld_val;
  wire       g_sw  = wr_en && sel_gpr;

  // Software and execution write through separate paths so that a
  // software write to another register is never lost. The execution
  // write comes last and wins when both name the same register.
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        gpr[i] <= exec_pkg::REG_RST;
      end
    end else begin
      if (g_sw) begin
        gpr[widx] <= wdata[7:0];
      end
      if (g_exec) begin
        gpr[cur.index] <= g_res;
      end
    end
  end

  // ****************************************
  // I/O registers
  // ****************************************
  // The read-modify-write lands in the second cycle of the op
  logic [7:0] io_mod;
  always_comb begin
    io_mod = ival;
    io_mod[cur.bit_sel] = cur.op == exec_pkg::OP_IO_BIT_SET;
  end

  wire       i_exec = in_hold && is_io;
  wire       i_sw   = wr_en && sel_io;

  // Same split as the general registers: the bit op wins on a clash
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < NUM_REGS; i++) begin
        io_reg[i] <= exec_pkg::REG_RST;
      end
    end else begin
      if (i_sw) begin
        io_reg[widx] <= wdata[7:0];
      end
      if (i_exec) begin
        io_reg[cur.index] <= io_mod;
      end
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  wire [31:0] rd_mux =
    sel_cmd  ? {7'h00, busy, cur} :
    sel_flag ? {24'h000000, status_flags_word} :
    sel_pc   ? {16'h0000, pc} :
    sel_gpr  ? {24'h000000, gpr[widx]} :
    sel_io   ? {24'h000000, io_reg[widx]} : 32'h00000000;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= 32'h00000000;
    end else begin
      // Zero outside the read cycle so a stale word is never taken as fresh
      rdata <= rd_en ? rd_mux : 32'h00000000;
    end
  end

endmodule

/* File: logic/exec_pkg.sv */
// Constants, command layout and opcodes of the bit, shift, flag and
// branch execution unit.
// Assumes a single core clock and a byte-addressed 32-bit register port with word-aligned registers.
package exec_pkg;

  // ****************************************
  // Register port map
  // ****************************************
  localparam int          ADDR_W    = 10;
  localparam int          DATA_W    = 32;
  localparam logic [9:0]  ADDR_CMD  = 10'h000;
  localparam logic [9:0]  ADDR_FLAGS = 10'h004;
  localparam logic [9:0]  ADDR_PC   = 10'h008;
  localparam logic [9:0]  GPR_BASE  = 10'h100;
  localparam logic [9:0]  IO_BASE   = 10'h200;
  // Each window is 32 words; the bits above this select the window
  localparam int          WIN_LSB   = 7;
  localparam int          IDX_LSB   = 2;

  // ****************************************
  // Status flag word layout and reset values
  // ****************************************
  localparam int          F_C = 0;
  localparam int          F_Z = 1;
  localparam int          F_N = 2;
  localparam int          F_V = 3;
  localparam int          F_S = 4;
  localparam int          F_H = 5;
  localparam int          F_T = 6;
  localparam int          F_I = 7;
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam int          PC_W      = 16;
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [7:0]  REG_RST   = 8'h00;

  // ****************************************
  // Opcodes
  // ****************************************
  typedef enum logic [5:0] {
    OP_NOP,
    OP_BRANCH_NO_OVERFLOW,
    OP_BRANCH_IRQ_ON,
    OP_BRANCH_IRQ_OFF,
    OP_BRANCH_FLAG_SET,
    OP_BRANCH_FLAG_CLEAR,
    OP_IO_BIT_SET,
    OP_IO_BIT_CLEAR,
    OP_SHIFT_LEFT_LOGICAL,
    OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_LEFT_CARRY,
    OP_ROTATE_RIGHT_CARRY,
    OP_SHIFT_RIGHT_ARITH,
    OP_NIBBLE_SWAP,
    OP_FLAG_SET,
    OP_FLAG_CLEAR,
    OP_BIT_TO_TRANSFER_FLAG,
    OP_TRANSFER_FLAG_TO_BIT,
    // Dedicated set/clear pairs, set first, in flag bit order
    OP_CARRY_SET,       OP_CARRY_CLEAR,
    OP_ZERO_SET,        OP_ZERO_CLEAR,
    OP_NEGATIVE_SET,    OP_NEGATIVE_CLEAR,
    OP_OVERFLOW_SET,    OP_OVERFLOW_CLEAR,
    OP_SIGNED_FLAG_SET, OP_SIGNED_FLAG_CLEAR,
    OP_HALF_CARRY_SET,  OP_HALF_CARRY_CLEAR,
    OP_TRANSFER_SET,    OP_TRANSFER_CLEAR,
    OP_IRQ_ENABLE_SET,  OP_IRQ_ENABLE_CLEAR
  } op_t;

  // Command word written to ADDR_CMD, low bits of the write data
  typedef struct packed {
    logic [6:0] offset;    // Signed branch offset
    logic [2:0] flag_sel;  // Status bit for generic flag ops
    logic [2:0] bit_sel;   // Bit within register
    logic [4:0] index;     // General or I/O register number
    op_t        op;
  } cmd_t;

  localparam int CMD_W = 24;

endpackage

/* File: sim/exec_unit_asserts.sv */
// Port-level checks of the execution unit's timing and flag effects.
// Assumes it is bound to exec_unit and sees only its ports.
`timescale 1ns/1ps

module exec_unit_asserts (
  // Clock and reset
  input wire logic                        clk,
  input wire logic                        sys_rst,
  // Register port
  input wire logic [exec_pkg::ADDR_W-1:0] addr,
  input wire logic [exec_pkg::DATA_W-1:0] wdata,
  input wire logic                        wr_en,
  input wire logic                        rd_en,
  input wire logic [exec_pkg::DATA_W-1:0] rdata,
  // Core state
  input wire logic                        busy,
  input wire logic                        done,
  input wire logic [7:0]                  status_flags_word,
  input wire logic [exec_pkg::PC_W-1:0]   pc
);
  // ****************************************
  // Command decode seen at the port
  // ****************************************
  wire        start = wr_en && addr == exec_pkg::ADDR_CMD && !busy;
  wire [5:0]  op    = wdata[5:0];
  wire [15:0] tgt   = pc + {{9{wdata[23]}}, wdata[23:17]} + 16'h0001;
  wire [5:0]  dsub  = op - 6'h12;
  wire [7:0]  dmask = 8'h01 << dsub[3:1];
  // Pairs run set then clear, so op bit 0 picks clear
  wire [7:0]  dexp  = op[0] ? (status_flags_word & ~dmask)
                            : (status_flags_word | dmask);
  wire        ded   = start && op >= 6'h12 && op <= 6'h21;
  wire        irqok = status_flags_word[7];

  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ****************************************
  // Properties
  // ****************************************
  chk_done_pulse: assert property (done |=> !done)
    else $error("done longer than one cycle");
  chk_rdata_idle: assert property (!$past(rd_en) |-> rdata == 32'h0)
    else $error("read data outside its cycle");
  chk_busy_bound: assert property ($rose(busy) |-> ##[1:2] !busy)
    else $error("busy too long");
  chk_ovf_taken: assert property (
    start && op == 6'h01 && !status_flags_word[3]
    |-> ##3 done && pc == $past(tgt, 3))
    else $error("overflow branch target wrong");
  chk_ovf_skip: assert property (
    start && op == 6'h01 && status_flags_word[3] |-> ##2 done && $stable(pc))
    else $error("overflow branch not skipped");
  chk_irq_taken: assert property (
    start && ((op == 6'h02 && irqok) || (op == 6'h03 && !irqok))
    |-> ##3 done && pc == $past(tgt, 3))
    else $error("interrupt branch target wrong");
  chk_branch_flags: assert property (
    start && op >= 6'h01 && op <= 6'h03 |=> ($stable(status_flags_word))[*2])
    else $error("branch changed flags");
  chk_io_cycles: assert property (
    start && (op == 6'h06 || op == 6'h07) |=> !done [*2] ##1 done)
    else $error("io bit op not two cycles");
  chk_shift_upper: assert property (
    start && op >= 6'h08 && op <= 6'h0c |-> ##2 done &&
    ((status_flags_word ^ $past(status_flags_word, 2)) & 8'hf0) == 8'h00)
    else $error("shift touched upper flags");
  chk_flag_only: assert property (
    ded |-> ##2 done && status_flags_word == $past(dexp, 2))
    else $error("flag op wrong");
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for exec_unit, driven over its register port.
// Assumes the register map and command layout of exec_pkg.
`timescale 1ns/1ps

module testbench;
  // ****************************************
  // Signals and tasks
  // ****************************************
  logic        clk, sys_rst, wr_en, rd_en, busy, done;
  logic [9:0]  addr;
  logic [31:0] wdata, rdata, c;
  logic [7:0]  flags, f0, m;
  logic [15:0] pc;
  logic [8:0]  r;
  logic [5:0]  op;
  logic [7:0]  v;
  int          num_errors, samples_checked, i, n;

  exec_unit dut_u (.clk(clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .busy(busy), .done(done),
    .status_flags_word(flags), .pc(pc));

  task stop_test;
    if (num_errors == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] e);
    samples_checked++;
    if (got !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task wr(input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [9:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, e);
  endtask

  // Cycles counted from the one after the command write
  task wait_done;
    n = 0;
    #1;
    while (done !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1 n++;
    end
    if (done !== 1'b1) begin
      num_errors++;
      $display("wrong value at %0t: done never came", $time);
      stop_test;
    end
  endtask

  task go(input logic [31:0] c, input int cyc);
    wr(exec_pkg::ADDR_CMD, c);
    wait_done;
    chk(32'(n), 32'(cyc));
  endtask

  function automatic logic [31:0] mk(input logic [5:0] o, input logic [4:0] x,
                                     input logic [2:0] b, input logic [6:0] k);
    mk = {8'h00, k, 3'h0, b, x, o};
  endfunction

  // Returns {carry out, result}
  function automatic logic [8:0] shf(input logic [5:0] o, input logic [7:0] a,
                                     input logic c);
    case (o)
      6'h08:   shf = {a, 1'b0};
      6'h09:   shf = {a[0], 1'b0, a[7:1]};
      6'h0a:   shf = {a, c};
      6'h0b:   shf = {a[0], c, a[7:1]};
      default: shf = {a[0], a[7], a[7:1]};
    endcase
  endfunction

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1; wr_en = 1'b0; rd_en = 1'b0; addr = 10'h000;
    wdata = 32'h0; num_errors = 0; samples_checked = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    rd(exec_pkg::ADDR_FLAGS, 32'h0);
    rd(exec_pkg::ADDR_PC, 32'h0);
    wr(10'h300, 32'hff);
    rd(10'h300, 32'h0);
    wr(exec_pkg::ADDR_FLAGS, 32'h00);
    wr(exec_pkg::ADDR_PC, 32'h0010);
    go(mk(6'h01, 5'h00, 3'h0, 7'h7d), 2);
    rd(exec_pkg::ADDR_PC, 32'h000e);
    wr(exec_pkg::ADDR_FLAGS, 32'h08);
    go(mk(6'h01, 5'h00, 3'h0, 7'h05), 1);
    rd(exec_pkg::ADDR_PC, 32'h000e);
    for (i = 0; i < 4; i++) begin
      f0 = i[0] ? 8'h80 : 8'h00;
      op = i[1] ? 6'h03 : 6'h02;
      wr(exec_pkg::ADDR_FLAGS, {24'h0, f0});
      wr(exec_pkg::ADDR_PC, 32'h0100);
      go(mk(op, 5'h00, 3'h0, 7'h3f), (i[1] ^ i[0]) ? 2 : 1);
      rd(exec_pkg::ADDR_PC, (i[1] ^ i[0]) ? 32'h140 : 32'h100);
      rd(exec_pkg::ADDR_FLAGS, {24'h0, f0});
    end
    wr(exec_pkg::ADDR_FLAGS, 32'h3c);
    wr(10'h214, 32'ha5);
    go(mk(6'h06, 5'h05, 3'h1, 7'h00), 2);
    rd(10'h214, 32'ha7);
    go(mk(6'h07, 5'h05, 3'h7, 7'h00), 2);
    rd(10'h214, 32'h27);
    // Second command lands while busy and must be dropped
    wr(exec_pkg::ADDR_CMD, mk(6'h06, 5'h05, 3'h3, 7'h00));
    wr(exec_pkg::ADDR_CMD, mk(6'h06, 5'h05, 3'h4, 7'h00));
    wait_done;
    rd(10'h214, 32'h2f);
    rd(exec_pkg::ADDR_FLAGS, 32'h3c);
    // A software write in the bit op's second cycle must not be lost
    wr(exec_pkg::ADDR_CMD, mk(6'h06, 5'h05, 3'h6, 7'h00));
    wr(10'h218, 32'h3c);
    wait_done;
    rd(10'h218, 32'h3c);
    rd(10'h214, 32'h6f);
    // Readback in the second cycle shows busy beside the command
    c = mk(6'h07, 5'h05, 3'h6, 7'h00);
    wr(exec_pkg::ADDR_CMD, c);
    rd(exec_pkg::ADDR_CMD, 32'h01000000 | c);
    wait_done;
    rd(10'h214, 32'h2f);
    for (i = 0; i < 15; i++) begin
      op = 6'h08 + 6'(i % 5);
      v = (i < 5) ? 8'h81 : (i < 10) ? 8'h80 : 8'h01;
      f0 = {7'h38, i[0]};
      r = shf(op, v, i[0]);
      wr(exec_pkg::ADDR_FLAGS, {24'h0, f0});
      wr(10'h10c, {24'h0, v});
      go(mk(op, 5'h03, 3'h0, 7'h00), 1);
      rd(10'h10c, {24'h0, r[7:0]});
      m = {4'h7, r[7] ^ r[8], r[7], r[7:0] == 8'h00, r[8]};
      rd(exec_pkg::ADDR_FLAGS, {24'h0, m});
    end
    wr(exec_pkg::ADDR_FLAGS, 32'h05);
    wr(10'h110, 32'h20);
    go(mk(6'h10, 5'h04, 3'h5, 7'h00), 1);
    rd(exec_pkg::ADDR_FLAGS, 32'h45);
    wr(10'h118, 32'h81);
    go(mk(6'h11, 5'h06, 3'h2, 7'h00), 1);
    rd(10'h118, 32'h85);
    rd(exec_pkg::ADDR_FLAGS, 32'h45);
    go(mk(6'h10, 5'h04, 3'h4, 7'h00), 1);
    rd(exec_pkg::ADDR_FLAGS, 32'h05);
    // Generic branch and flag ops pick T (6) or H (5) through flag_sel
    wr(exec_pkg::ADDR_FLAGS, 32'h40);
    wr(exec_pkg::ADDR_PC, 32'h0020);
    go(mk(6'h04, 5'h00, 3'h0, 7'h10) | 32'h00018000, 2);
    rd(exec_pkg::ADDR_PC, 32'h0031);
    go(mk(6'h05, 5'h00, 3'h0, 7'h10) | 32'h00018000, 1);
    rd(exec_pkg::ADDR_PC, 32'h0031);
    go(mk(6'h0e, 5'h00, 3'h0, 7'h00) | 32'h00014000, 1);
    rd(exec_pkg::ADDR_FLAGS, 32'h60);
    go(mk(6'h0f, 5'h00, 3'h0, 7'h00) | 32'h00018000, 1);
    rd(exec_pkg::ADDR_FLAGS, 32'h20);
    wr(10'h11c, 32'h5a);
    go(mk(6'h0d, 5'h07, 3'h0, 7'h00), 1);
    rd(10'h11c, 32'ha5);
    rd(exec_pkg::ADDR_CMD, mk(6'h0d, 5'h07, 3'h0, 7'h00));
    for (i = 18; i < 34; i++) begin
      m = 8'h01 << ((i - 18) >> 1);
      wr(exec_pkg::ADDR_FLAGS, 32'h5a);
      go(mk(6'(i), 5'h00, 3'h0, 7'h00), 1);
      m = i[0] ? (8'h5a & ~m) : (8'h5a | m);
      rd(exec_pkg::ADDR_FLAGS, {24'h0, m});
    end
    stop_test;
  end
endmodule

bind exec_unit exec_unit_asserts chk_u (.clk, .sys_rst, .addr, .wdata,
  .wr_en, .rd_en, .rdata, .busy, .done, .status_flags_word, .pc);
